// ===== rtl/irq_map_defs.vh
// Constants for the interrupt pin mapper and FIFO threshold registers
`ifndef IRQ_MAP_DEFS_VH
`define IRQ_MAP_DEFS_VH

// Register bus widths
`define ADDR_W 8
`define DATA_W 8

// Register byte addresses
`define ADDR_FIFO_CTRL 8'h28
`define ADDR_THRESH_LOW 8'h29
`define ADDR_FIRST_MAP 8'h2a
`define ADDR_SECOND_MAP 8'h2b
`define ADDR_FLAG_VIEW 8'h3c
`define ADDR_PIN_VIEW 8'h3d
`define ADDR_ENTRY_LOW 8'h3e
`define ADDR_ENTRY_HIGH 8'h3f

// Reset values
`define RST_THRESH_LOW 8'h80
`define RST_MAP 8'h00
`define RST_MSB 1'h0
`define RST_AXES 2'h3
`define RST_BYTE 8'h00

// Stored axes codes in the control register of the FIFO
`define AXES_ONE 2'h1
`define AXES_TWO 2'h2
`define AXES_THREE 2'h3

// Field positions in the control register of the FIFO
`define CTRL_MSB_BIT 3
`define CTRL_AXES_HI 5
`define CTRL_AXES_LO 4

// Field positions in each pin map register
`define MAP_POL_BIT 7
`define MAP_SRC_HI 6
`define MAP_SRC_LO 0
`define MAP_AWAKE 6
`define MAP_IDLE 5
`define MAP_MOTION 4
`define MAP_OVERFLOW 3
`define MAP_THRESH 2
`define MAP_QREADY 1
`define MAP_NEWSAMP 0

// Widths of derived quantities
`define SRC_W 7
`define COUNT_W 9
`define ENTRY_W 11
`define AXES_W 2
`define PIN_N 2
`define ENTRY_HI_W 3

`endif

// ===== rtl/irq_pin_mapper.v
// Interrupt pin mapper with FIFO threshold count registers
`timescale 1ns/1ns
`include "irq_map_defs.vh"

// Behaviour
// - Threshold low byte is an R/W register
// - Threshold ninth bit lives in FIFO control
// - Count means sample sets, times stored axes
// - Threshold low byte resets to 0x80
// - Map bit 7 set makes pin active low
// - First map bit 6 routes awake
// - First map bit 5 routes inactivity
// - First map bit 4 routes activity
// - First map bit 3 routes FIFO overrun
// - First map bit 2 routes FIFO watermark
// - First map bit 1 routes FIFO ready
// - First map bit 0 routes data ready
// - Second map bit 6 routes awake
// - Second map bit 5 routes inactivity
// - Second map bit 4 routes activity
// - Second map bit 3 routes FIFO overrun
// - Second map bit 2 routes FIFO watermark
// - Second map bit 1 routes FIFO ready
// - Second map bit 0 routes data ready
// - Both map registers reset to zero

module irq_pin_mapper
(
    // Clock and reset
    input wire clock,
    input wire rst,

    // Register port
    input wire [`ADDR_W-1:0] addr,
    input wire [`DATA_W-1:0] wdata,
    input wire wr,
    input wire rd,
    output wire [`DATA_W-1:0] rdata,

    // Status flags from the sensing core
    input wire awake_flag,
    input wire idle_flag,
    input wire motion_flag,
    input wire overflow_flag,
    input wire queue_threshold_flag,
    input wire queue_ready_flag,
    input wire new_sample_flag,

    // Interrupt pins toward the host
    output wire first_irq_pin,
    output wire second_irq_pin,

    // Threshold toward the FIFO
    output wire [`COUNT_W-1:0] threshold_count,
    output wire [`ENTRY_W-1:0] threshold_entries
);

    // Software visible state
    reg [`DATA_W-1:0] thresh_low_r;
    reg thresh_msb_r;
    reg [`AXES_W-1:0] axes_r;
    reg [`DATA_W-1:0] first_map_r;
    reg [`DATA_W-1:0] second_map_r;

    // Read data, valid only in the cycle after a read
    reg [`DATA_W-1:0] rdata_r;
    reg [`DATA_W-1:0] rdata_nxt;

    // Pin and threshold output flops
    reg [`PIN_N-1:0] pin_r;
    reg [`PIN_N-1:0] hit_r;
    reg [`ENTRY_W-1:0] entries_r;
    reg [`ENTRY_W-1:0] entries_nxt;

    // Flag vector laid out like the source field of a map
    wire [`SRC_W-1:0] flags;
    wire [`DATA_W-1:0] maps [0:`PIN_N-1];
    wire [`COUNT_W-1:0] count;
    wire [`ENTRY_W-1:0] count_wide;

    // Per pin vectors of sources that are both flagged and enabled
    reg [`SRC_W-1:0] en_first;
    reg [`SRC_W-1:0] en_second;
    wire [`SRC_W-1:0] routed [0:`PIN_N-1];

    // Decoded write strobes
    reg wr_ctrl;
    reg wr_low;
    reg wr_first;
    reg wr_second;

    // Place each source at the bit that enables it
    assign flags[`MAP_AWAKE] = awake_flag;
    assign flags[`MAP_IDLE] = idle_flag;
    assign flags[`MAP_MOTION] = motion_flag;
    assign flags[`MAP_OVERFLOW] = overflow_flag;
    assign flags[`MAP_THRESH] = queue_threshold_flag;
    assign flags[`MAP_QREADY] = queue_ready_flag;
    assign flags[`MAP_NEWSAMP] = new_sample_flag;

    // Index the two map registers by pin number
    assign maps[0] = first_map_r;
    assign maps[1] = second_map_r;

    // First pin: each source gated by its own map bit
    always @*
    begin
        en_first = {`SRC_W{1'b0}};
        en_first[`MAP_AWAKE] = first_map_r[`MAP_AWAKE] & awake_flag;
        en_first[`MAP_IDLE] = first_map_r[`MAP_IDLE] & idle_flag;
        en_first[`MAP_MOTION] = first_map_r[`MAP_MOTION] & motion_flag;
        en_first[`MAP_OVERFLOW] =
            first_map_r[`MAP_OVERFLOW] & overflow_flag;
        en_first[`MAP_THRESH] =
            first_map_r[`MAP_THRESH] & queue_threshold_flag;
        en_first[`MAP_QREADY] =
            first_map_r[`MAP_QREADY] & queue_ready_flag;
        en_first[`MAP_NEWSAMP] =
            first_map_r[`MAP_NEWSAMP] & new_sample_flag;
    end

    // Second pin: its own map, so the two pins never share enables
    always @*
    begin
        en_second = {`SRC_W{1'b0}};
        en_second[`MAP_AWAKE] = second_map_r[`MAP_AWAKE] & awake_flag;
        en_second[`MAP_IDLE] = second_map_r[`MAP_IDLE] & idle_flag;
        en_second[`MAP_MOTION] =
            second_map_r[`MAP_MOTION] & motion_flag;
        en_second[`MAP_OVERFLOW] =
            second_map_r[`MAP_OVERFLOW] & overflow_flag;
        en_second[`MAP_THRESH] =
            second_map_r[`MAP_THRESH] & queue_threshold_flag;
        en_second[`MAP_QREADY] =
            second_map_r[`MAP_QREADY] & queue_ready_flag;
        en_second[`MAP_NEWSAMP] =
            second_map_r[`MAP_NEWSAMP] & new_sample_flag;
    end

    // Index the gated sources by pin number for the shared driver
    assign routed[0] = en_first;
    assign routed[1] = en_second;

    // Full nine bit count from its two homes
    assign count = {thresh_msb_r, thresh_low_r};

    // Address decode for writes; view registers ignore writes
    always @*
    begin
        wr_ctrl = 1'b0;
        wr_low = 1'b0;
        wr_first = 1'b0;
        wr_second = 1'b0;
        if (wr)
        begin
            case (addr)
                `ADDR_FIFO_CTRL:
                begin
                    wr_ctrl = 1'b1;
                end
                `ADDR_THRESH_LOW:
                begin
                    wr_low = 1'b1;
                end
                `ADDR_FIRST_MAP:
                begin
                    wr_first = 1'b1;
                end
                `ADDR_SECOND_MAP:
                begin
                    wr_second = 1'b1;
                end
                default:
                begin
                    wr_ctrl = 1'b0;
                end
            endcase
        end
    end

    // Control register of the FIFO: ninth bit and axes stored
    always @(posedge clock)
    begin
        if (rst)
        begin
            thresh_msb_r <= `RST_MSB;
            axes_r <= `RST_AXES;
        end
        else if (wr_ctrl)
        begin
            thresh_msb_r <= wdata[`CTRL_MSB_BIT];
            axes_r <= wdata[`CTRL_AXES_HI:`CTRL_AXES_LO];
        end
    end

    // Low byte of the threshold; default keeps watermark quiet
    always @(posedge clock)
    begin
        if (rst)
        begin
            thresh_low_r <= `RST_THRESH_LOW;
        end
        else if (wr_low)
        begin
            thresh_low_r <= wdata;
        end
    end

    // Map register of the first pin
    always @(posedge clock)
    begin
        if (rst)
        begin
            first_map_r <= `RST_MAP;
        end
        else if (wr_first)
        begin
            first_map_r <= wdata;
        end
    end

    // Map register of the second pin
    always @(posedge clock)
    begin
        if (rst)
        begin
            second_map_r <= `RST_MAP;
        end
        else if (wr_second)
        begin
            second_map_r <= wdata;
        end
    end

    // Widen the count before any arithmetic so no carry is lost
    assign count_wide = {{(`ENTRY_W-`COUNT_W){1'b0}}, count};

    // Sets times axes gives stored entries; adds avoid a multiplier
    always @*
    begin
        entries_nxt = {`ENTRY_W{1'b0}};
        case (axes_r)
            `AXES_ONE:
            begin
                entries_nxt = count_wide;
            end
            `AXES_TWO:
            begin
                entries_nxt = count_wide + count_wide;
            end
            `AXES_THREE:
            begin
                entries_nxt = count_wide + count_wide + count_wide;
            end
            default:
            begin
                entries_nxt = {`ENTRY_W{1'b0}}; // No axes, nothing stored
            end
        endcase
    end

    // Registered so the FIFO sees a clean value
    always @(posedge clock)
    begin
        if (rst)
        begin
            entries_r <= {`ENTRY_W{1'b0}};
        end
        else
        begin
            entries_r <= entries_nxt;
        end
    end

    // One identical pin driver per interrupt pin
    genvar p;
    generate
        for (p = 0; p < `PIN_N; p = p + 1)
        begin : pin_drv
            wire [`SRC_W-1:0] enabled;
            wire hit;
            wire level;

            // Only sources whose map bit is set take part
            assign enabled = routed[p];

            // Any one enabled source asserts the pin
            assign hit = |enabled;

            // Polarity bit inverts the driven level
            assign level = hit ^ maps[p][`MAP_POL_BIT];

            // The pin flop costs one cycle but gives glitch free edges
            always @(posedge clock)
            begin
                if (rst)
                begin
                    pin_r[p] <= 1'b0;
                    hit_r[p] <= 1'b0;
                end
                else
                begin
                    pin_r[p] <= level;
                    hit_r[p] <= hit;
                end
            end
        end
    endgenerate

    // First pin straight from its flop
    assign first_irq_pin = pin_r[0];

    // Second pin straight from its flop
    assign second_irq_pin = pin_r[1];

    // Read multiplexer; unmapped addresses read as zero
    always @*
    begin
        rdata_nxt = `RST_BYTE;
        if (rd)
        begin
            case (addr)
                `ADDR_FIFO_CTRL:
                begin
                    rdata_nxt[`CTRL_MSB_BIT] = thresh_msb_r;
                    rdata_nxt[`CTRL_AXES_HI:`CTRL_AXES_LO] = axes_r;
                end
                `ADDR_THRESH_LOW:
                begin
                    rdata_nxt = thresh_low_r;
                end
                `ADDR_FIRST_MAP:
                begin
                    rdata_nxt = first_map_r;
                end
                `ADDR_SECOND_MAP:
                begin
                    rdata_nxt = second_map_r;
                end
                `ADDR_FLAG_VIEW:
                begin
                    rdata_nxt[`MAP_SRC_HI:`MAP_SRC_LO] = flags;
                end
                `ADDR_PIN_VIEW:
                begin
                    rdata_nxt[`PIN_N-1:0] = hit_r;
                    rdata_nxt[2*`PIN_N-1:`PIN_N] = pin_r;
                end
                `ADDR_ENTRY_LOW:
                begin
                    rdata_nxt = entries_r[`DATA_W-1:0];
                end
                `ADDR_ENTRY_HIGH:
                begin
                    rdata_nxt[`ENTRY_HI_W-1:0] =
                        entries_r[`ENTRY_W-1:`DATA_W];
                end
                default:
                begin
                    rdata_nxt = `RST_BYTE;
                end
            endcase
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always @(posedge clock)
    begin
        if (rst)
        begin
            rdata_r <= `RST_BYTE;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata = rdata_r;
    assign threshold_count = count;
    assign threshold_entries = entries_r;

endmodule

// ===== verif/irq_host_model.sv
// Host model that decodes the two interrupt pins
`timescale 1ns/1ns
module irq_host_model
(
    // Clock and pins
    input wire clock,
    input wire first_irq_pin,
    input wire second_irq_pin,
    // Polarity the host expects per pin
    input wire [1:0] active_low,
    // Decoded requests, bit 0 first pin
    output reg [1:0] irq_seen
);
    // Sampled on the host edge, so one cycle behind the pins
    always @(posedge clock)
        irq_seen <= {second_irq_pin, first_irq_pin} ^ active_low;
endmodule

// ===== verif/irq_pin_mapper_assertions.sv
// Port assertions for the interrupt pin mapper
`timescale 1ns/1ns
module irq_pin_mapper_chk
(
    // Clock, reset and register port
    input wire clock,
    input wire rst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    // Status flags
    input wire awake_flag,
    input wire idle_flag,
    input wire motion_flag,
    input wire overflow_flag,
    input wire queue_threshold_flag,
    input wire queue_ready_flag,
    input wire new_sample_flag,
    // Outputs
    input wire first_irq_pin,
    input wire second_irq_pin,
    input wire [8:0] threshold_count,
    input wire [10:0] threshold_entries
);
    reg [7:0] low_r;
    reg [7:0] m1_r;
    reg [7:0] m2_r;
    reg [7:0] ctl_r;
    wire [6:0] fl;
    // Flags in map bit order
    assign fl = {awake_flag, idle_flag, motion_flag, overflow_flag,
        queue_threshold_flag, queue_ready_flag, new_sample_flag};
    // Shadow of the writable registers, updated on the same edge
    always @(posedge clock)
    begin
        if (rst)
        begin
            low_r <= 8'h80;
            m1_r <= 8'h00;
            m2_r <= 8'h00;
            ctl_r <= 8'h30;
        end
        else if (wr)
        begin
            if (addr == 8'h28)
                ctl_r <= wdata;
            if (addr == 8'h29)
                low_r <= wdata;
            if (addr == 8'h2a)
                m1_r <= wdata;
            if (addr == 8'h2b)
                m2_r <= wdata;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_pin1;
        !$past(rst) |-> first_irq_pin == $past((|(m1_r[6:0] & fl)) ^ m1_r[7]);
    endproperty
    a_pin1: assert property (p_pin1) else $error("first pin wrong");
    property p_pin2;
        !$past(rst) |-> second_irq_pin == $past((|(m2_r[6:0] & fl)) ^ m2_r[7]);
    endproperty
    a_pin2: assert property (p_pin2) else $error("second pin wrong");
    property p_count;
        threshold_count == {ctl_r[3], low_r};
    endproperty
    a_count: assert property (p_count) else $error("count wrong");
    property p_ent;
        !$past(rst) |->
            threshold_entries == $past({2'h0, threshold_count} * ctl_r[5:4]);
    endproperty
    a_ent: assert property (p_ent) else $error("entries wrong");
    property p_rdlow;
        rd && addr == 8'h29 |=> rdata == $past(low_r);
    endproperty
    a_rdlow: assert property (p_rdlow) else $error("low read wrong");
    property p_rdmap;
        rd && addr[7:1] == 7'h15 |=> rdata == $past(addr[0] ? m2_r : m1_r);
    endproperty
    a_rdmap: assert property (p_rdmap) else $error("map read wrong");
    property p_quiet;
        !rd |=> rdata == 8'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("rdata not idle");
    property p_rst;
        $fell(rst) |-> threshold_count == 9'h080 && !second_irq_pin;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule
bind irq_pin_mapper irq_pin_mapper_chk i_chk (.*);

// ===== verif/testbench.sv
// Self-checking testbench for the interrupt pin mapper
`timescale 1ns/1ns
module testbench;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [6:0] fl = 7'h00;
    reg [1:0] pol = 2'h0;
    reg [7:0] d;
    wire [7:0] rdata;
    wire p1;
    wire p2;
    wire [8:0] tcount;
    wire [10:0] tent;
    wire [1:0] seen;
    integer fails = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    integer p;
    integer b;
    always #25 clock = ~clock;
    irq_pin_mapper i_irq_pin_mapper (.clock(clock), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .awake_flag(fl[6]),
        .idle_flag(fl[5]), .motion_flag(fl[4]), .overflow_flag(fl[3]),
        .queue_threshold_flag(fl[2]), .queue_ready_flag(fl[1]),
        .new_sample_flag(fl[0]), .first_irq_pin(p1), .second_irq_pin(p2),
        .threshold_count(tcount), .threshold_entries(tent));
    irq_host_model i_irq_host_model (.clock(clock), .first_irq_pin(p1),
        .second_irq_pin(p2), .active_low(pol), .irq_seen(seen));
    task check(input [15:0] s, input [15:0] e);
    begin
        cmp_count = cmp_count + 1;
        if (s !== e)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    end
    endtask
    task test_done;
    begin
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            fails = fails + 1;
            test_done;
        end
    end
    task wr_reg(input [7:0] a, input [7:0] v);
    begin
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
    end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd_reg(input [7:0] a);
    begin
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    end
    endtask
    task t_reset;
    begin
        rd_reg(8'h29);
        check(d, 8'h80);
        rd_reg(8'h2a);
        check(d, 8'h00);
        rd_reg(8'h2b);
        check(d, 8'h00);
        check(tcount, 9'h080);
        check(tent, 11'h180);
        check({p2, p1}, 2'h0);
    end
    endtask
    // Full count with one axis, then three axes, then zero
    task t_count;
    begin
        wr_reg(8'h29, 8'hff);
        wr_reg(8'h28, 8'h18);
        #1 check(tcount, 9'h1ff);
        rd_reg(8'h29);
        check(d, 8'hff);
        check(tent, 11'h1ff);
        wr_reg(8'h28, 8'h38);
        repeat (2) @(posedge clock);
        #1 check(tent, 11'h5fd);
        rd_reg(8'h3e);
        check(d, 8'hfd);
        rd_reg(8'h3f);
        check(d, 8'h05);
        rd_reg(8'h28);
        check(d, 8'h38);
        wr_reg(8'h28, 8'h30);
        wr_reg(8'h29, 8'h00);
        #1 check(tcount, 9'h000);
        rd_reg(8'h50);
        check(d, 8'h00);
    end
    endtask
    // Each source alone, others all active but unmapped
    task t_route;
    begin
        for (p = 0; p < 2; p = p + 1)
            for (b = 0; b < 7; b = b + 1)
            begin
                wr_reg(8'h2a + p, {b[0], 7'h01 << b});
                wr_reg(8'h2b - p, 8'h00);
                @(posedge clock);
                pol <= {1'b0, b[0]} << p;
                fl <= ~(7'h01 << b);
                repeat (3) @(posedge clock);
                #1 check(seen, 2'h0);
                check(p ? p2 : p1, b[0]);
                @(posedge clock);
                fl <= 7'h01 << b;
                repeat (3) @(posedge clock);
                #1 check(seen, 2'h1 << p);
            end
    end
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_count;
        t_route;
        test_done;
    end
endmodule
